// file: core/oms_pkg.sv
// package for the operating mode sequencer: modes, init phases, timing counts
// assumes a single 40 MHz reference clock
package oms_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_HZ = 40_000_000;
    localparam int WAKE_TIME_US = 100;
    localparam int WAKE_CYCLES = (WAKE_TIME_US * (CLK_HZ / 1_000_000));
    localparam int SHD_TIME_MS = 128;
    localparam int SHD_CYCLES = SHD_TIME_MS * (CLK_HZ / 1000);
    localparam int STANDBY_HOLD_CYCLES = 5;
    localparam int FUSE_PULSE_CYCLES = 4;
    localparam int FUSE_LOAD_CYCLES = 8;
    localparam int RES_TIMEOUT_CYCLES = 64;
    localparam int DEBOUNCE_CYCLES = 4;
    localparam int CNT_W = 24;

    // ==========================================================
    // regulator defaults before the fuse settings land
    localparam logic [1:0] VCC_SEL_3V3 = 2'h0;
    localparam logic [1:0] UVR_SEL_2V75 = 2'h0;
    localparam logic SHDN_CTRL_RESET = 1'h0;

    // ==========================================================
    // modes and init phases
    typedef enum logic [2:0] {
        OMS_INIT = 3'b000,
        OMS_NORMAL = 3'b001,
        OMS_STANDBY = 3'b010,
        OMS_SLEEP = 3'b011,
        OMS_TEMP_SHDN = 3'b100,
        OMS_THERM_SHDN = 3'b101
    } oms_mode_e;

    typedef enum logic [2:0] {
        INI_WAIT_VCC = 3'b000,
        INI_FUSE_PULSE = 3'b001,
        INI_FUSE_LOAD = 3'b010,
        INI_PREREG = 3'b011,
        INI_WAIT_VCC2 = 3'b100,
        INI_RES_TIMEOUT = 3'b101
    } oms_init_e;

    // block enables as one group
    typedef struct packed {
        logic regulator;
        logic transceiver;
        logic window_wd;
        logic tx_timeout_wd;
        logic divider;
        logic drivers;
        logic wake_det;
        logic temp_mon;
        logic reset_unit;
    } oms_en_s;

endpackage

// file: core/oms_sequencer.sv
// operating mode sequencer: modes, power-up init, tx gating, rx debounce
// assumes all inputs synchronous to i_ref_clk; analog events arrive as levels
//
// Overview of operation
// - after power-up, normal mode with every block enabled
// - warning temperature sets a sticky warning flag
// - standby disables transceiver, watchdogs, divider, drivers; keeps wake and temp monitor
// - sleep option switches off regulator, transceiver, reset, watchdog
// - sleep left by bus dominant about 100 us, back to normal, or by over threshold temperature
// - temporary shutdown usable only with fuse enable option
// - temporary shutdown powers down regulator, transceiver and wake detector
// - temporary shutdown ends after 128 ms timer, returns to normal
// - normal enters temporary shutdown when shutdown bit set and mode pin high
// - standby enters temporary shutdown when shutdown bit set
// - over threshold temperature enters thermal shutdown from any mode but temporary shutdown, sets overtemp flag
// - thermal shutdown ignores local and remote wake
// - temperature return reruns initialization regardless of pins
// - standby returns to normal on mode pin rise or remote wake
// - bus low for wake time from standby or sleep gives normal
// - tx relaying blocked in every mode but normal and while i_rstn is low; vcc reset does not block it
// - regulator starts at 3.3 V and 2.75 V release until fuses load
// - fuse power-on pulse, load latch, strobe latch into pre-regulator
// - vcc good again restarts reset timeout, then release reset, normal
// - reinitialization after overtemp drops low slew selection
// - bus level passed to rx through a spike debouncer
// - shutdown bit requests temporary shutdown, resets to zero on vcc reset
`timescale 1ns/1ps
`default_nettype none

module oms_sequencer
    import oms_pkg::*;
#(
    parameter int SHD_COUNT = SHD_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_vcc_reset_n,
    input wire logic i_vcc_above_release,
    input wire logic i_temp_warning,
    input wire logic i_temp_over,
    input wire logic i_temp_returned,
    input wire logic i_opt_sleep,
    input wire logic i_opt_temp_shdn,
    input wire logic i_mode_pin,
    input wire logic i_tx,
    input wire logic i_bus,
    input wire logic i_shdn_wr,
    input wire logic i_shdn_wdata,
    input wire logic i_low_slew_wr,
    input wire logic i_low_slew_wdata,
    input wire logic i_warn_clear,
    input wire logic i_ot_clear,
    input wire logic [3:0] i_fuse_data,
    output logic o_fuse_power_on_n,
    output logic o_latch_to_prereg_strobe,
    output logic [3:0] o_prereg_settings,
    output logic [1:0] o_vcc_sel,
    output logic [1:0] o_uvr_sel,
    output logic o_ext_reset_n,
    output logic o_tx_to_bus,
    output logic o_rx,
    output logic o_low_slew,
    output logic o_shdn_ctrl,
    output logic o_warn_flag,
    output logic o_overtemp_reset_flag,
    output oms_mode_e o_mode,
    output oms_en_s o_enables
);

    // ==========================================================
    // state
    oms_mode_e mode;
    oms_init_e init_ph;
    logic [CNT_W-1:0] cnt;
    logic [3:0] fuse_latch;
    logic mode_pin_d;
    logic [2:0] hold_cnt;
    logic standby_arm;
    logic [CNT_W-1:0] wake_cnt;
    logic [2:0] deb_cnt;
    logic remote_wake;
    logic prereg_loaded;

    assign remote_wake = (wake_cnt >= CNT_W'(WAKE_CYCLES));
    assign o_mode = mode;

    // ==========================================================
    // mode pin edges and standby request qualification
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            mode_pin_d <= 1'b0;
        end else begin
            mode_pin_d <= i_mode_pin;
        end
    end

    // tx must stay high for the hold count after the mode pin fall
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn || mode != OMS_NORMAL) begin
            hold_cnt <= 3'h0;
            standby_arm <= 1'b0;
        end else if (mode_pin_d && !i_mode_pin) begin
            hold_cnt <= 3'h1;
            standby_arm <= i_tx;
        end else if (standby_arm && !i_mode_pin && i_tx
                     && hold_cnt < 3'(STANDBY_HOLD_CYCLES)) begin
            hold_cnt <= hold_cnt + 3'h1;
        end else if (!i_tx || i_mode_pin) begin
            standby_arm <= 1'b0;
        end
    end

    // ==========================================================
    // bus wake detector: counts continuous dominant time
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn || i_bus || !o_enables.wake_det) begin
            wake_cnt <= '0;
        end else if (!remote_wake) begin
            wake_cnt <= wake_cnt + CNT_W'(1);
        end
    end

    // ==========================================================
    // main mode machine and init sequence
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            mode <= OMS_INIT;
            init_ph <= INI_WAIT_VCC;
            cnt <= '0;
            prereg_loaded <= 1'b0;
        end else begin
            unique case (mode)
                OMS_INIT: begin
                    unique case (init_ph)
                        INI_WAIT_VCC: begin
                            if (i_vcc_above_release) begin
                                init_ph <= INI_FUSE_PULSE;
                                cnt <= '0;
                            end
                        end
                        INI_FUSE_PULSE: begin
                            cnt <= cnt + CNT_W'(1);
                            if (cnt == CNT_W'(FUSE_PULSE_CYCLES - 1)) begin
                                init_ph <= INI_FUSE_LOAD;
                                cnt <= '0;
                            end
                        end
                        INI_FUSE_LOAD: begin
                            cnt <= cnt + CNT_W'(1);
                            if (cnt == CNT_W'(FUSE_LOAD_CYCLES - 1)) begin
                                init_ph <= INI_PREREG;
                            end
                        end
                        INI_PREREG: begin
                            prereg_loaded <= 1'b1;
                            init_ph <= INI_WAIT_VCC2;
                        end
                        INI_WAIT_VCC2: begin
                            if (i_vcc_above_release) begin
                                init_ph <= INI_RES_TIMEOUT;
                                cnt <= '0;
                            end
                        end
                        INI_RES_TIMEOUT: begin
                            cnt <= cnt + CNT_W'(1);
                            if (!i_vcc_above_release) begin
                                cnt <= '0; // restart while vcc dips
                            end else if (cnt == CNT_W'(RES_TIMEOUT_CYCLES - 1)) begin
                                mode <= OMS_NORMAL;
                            end
                        end
                        default: init_ph <= INI_WAIT_VCC;
                    endcase
                    if (i_temp_over) begin
                        mode <= OMS_THERM_SHDN;
                    end
                end
                OMS_NORMAL: begin
                    if (i_temp_over) begin
                        mode <= OMS_THERM_SHDN;
                    end else if (o_shdn_ctrl && i_opt_temp_shdn && i_mode_pin) begin
                        mode <= OMS_TEMP_SHDN;
                        cnt <= '0;
                    end else if (standby_arm && !o_shdn_ctrl
                                 && hold_cnt == 3'(STANDBY_HOLD_CYCLES)) begin
                        mode <= i_opt_sleep ? OMS_SLEEP : OMS_STANDBY;
                    end
                end
                OMS_STANDBY: begin
                    if (i_temp_over) begin
                        mode <= OMS_THERM_SHDN;
                    end else if (o_shdn_ctrl && i_opt_temp_shdn) begin
                        mode <= OMS_TEMP_SHDN;
                        cnt <= '0;
                    end else if ((!mode_pin_d && i_mode_pin) || remote_wake) begin
                        mode <= OMS_NORMAL;
                    end
                end
                OMS_SLEEP: begin
                    if (i_temp_over) begin
                        mode <= OMS_THERM_SHDN;
                    end else if (remote_wake) begin
                        mode <= OMS_NORMAL;
                    end
                end
                OMS_TEMP_SHDN: begin
                    cnt <= cnt + CNT_W'(1);
                    if (cnt == CNT_W'(SHD_COUNT - 1)) begin
                        mode <= OMS_NORMAL;
                    end
                end
                OMS_THERM_SHDN: begin
                    // no wake source is looked at here
                    if (i_temp_returned && !i_temp_over) begin
                        mode <= OMS_INIT;
                        init_ph <= INI_WAIT_VCC;
                        prereg_loaded <= 1'b0;
                        cnt <= '0;
                    end
                end
                default: mode <= OMS_INIT;
            endcase
        end
    end

    // ==========================================================
    // fuse handshake and regulator settings
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            fuse_latch <= 4'h0;
            o_prereg_settings <= 4'h0;
        end else begin
            if (mode == OMS_INIT && init_ph == INI_FUSE_LOAD
                && cnt == CNT_W'(FUSE_LOAD_CYCLES - 1)) begin
                fuse_latch <= i_fuse_data;
            end
            if (mode == OMS_INIT && init_ph == INI_PREREG) begin
                o_prereg_settings <= fuse_latch;
            end
        end
    end

    assign o_fuse_power_on_n = !(mode == OMS_INIT && init_ph == INI_FUSE_PULSE);
    assign o_latch_to_prereg_strobe = (mode == OMS_INIT && init_ph == INI_PREREG);
    // defaults hold until the strobe lands the fuse settings
    assign o_vcc_sel = prereg_loaded ? o_prereg_settings[1:0] : VCC_SEL_3V3;
    assign o_uvr_sel = prereg_loaded ? o_prereg_settings[3:2] : UVR_SEL_2V75;
    assign o_ext_reset_n = (mode != OMS_INIT) && (mode != OMS_THERM_SHDN)
                           && (mode != OMS_TEMP_SHDN) && i_vcc_reset_n;

    // ==========================================================
    // control bits and flags
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn || !i_vcc_reset_n) begin
            o_shdn_ctrl <= SHDN_CTRL_RESET;
        end else if (mode == OMS_TEMP_SHDN) begin
            o_shdn_ctrl <= 1'b0;
        end else if (i_shdn_wr) begin
            o_shdn_ctrl <= i_shdn_wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn || mode == OMS_INIT) begin
            o_low_slew <= 1'b0;
        end else if (i_low_slew_wr) begin
            o_low_slew <= i_low_slew_wdata;
        end
    end

    // set wins over clear
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_warn_flag <= 1'b0;
            o_overtemp_reset_flag <= 1'b0;
        end else begin
            if (i_temp_warning) begin
                o_warn_flag <= 1'b1;
            end else if (i_warn_clear) begin
                o_warn_flag <= 1'b0;
            end
            if (i_temp_over) begin
                o_overtemp_reset_flag <= 1'b1;
            end else if (i_ot_clear) begin
                o_overtemp_reset_flag <= 1'b0;
            end
        end
    end

    // ==========================================================
    // block enables per mode
    always_comb begin
        o_enables = '0;
        o_enables.temp_mon = 1'b1;
        unique case (mode)
            OMS_NORMAL: begin
                o_enables = '1;
            end
            OMS_STANDBY: begin
                o_enables.regulator = 1'b1;
                o_enables.reset_unit = 1'b1;
                o_enables.wake_det = 1'b1;
            end
            OMS_SLEEP: begin
                o_enables.wake_det = 1'b1;
            end
            OMS_INIT: begin
                o_enables.regulator = 1'b1;
                o_enables.reset_unit = 1'b1;
            end
            OMS_TEMP_SHDN, OMS_THERM_SHDN: begin
                o_enables.temp_mon = 1'b1;
            end
            default: o_enables = '0;
        endcase
    end

    // ==========================================================
    // tx gating and rx debounce
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn || mode == OMS_SLEEP || mode == OMS_THERM_SHDN) begin
            o_tx_to_bus <= 1'b1;
        end else begin
            o_tx_to_bus <= o_enables.transceiver ? i_tx : 1'b1;
        end
    end

    // bus must disagree with rx for the full count before rx follows
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_rx <= 1'b1;
            deb_cnt <= 3'h0;
        end else if (i_bus == o_rx) begin
            deb_cnt <= 3'h0;
        end else if (deb_cnt == 3'(DEBOUNCE_CYCLES - 1)) begin
            o_rx <= i_bus;
            deb_cnt <= 3'h0;
        end else begin
            deb_cnt <= deb_cnt + 3'h1;
        end
    end

    // ==========================================================
    // assertions
    sequence s_tshd_entry;
        mode == OMS_NORMAL && !i_temp_over && o_shdn_ctrl && i_opt_temp_shdn && i_mode_pin;
    endsequence

    property p_tshd_entry;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        s_tshd_entry |=> mode == OMS_TEMP_SHDN;
    endproperty
    a_tshd_entry: assert property (p_tshd_entry) else $error("no temp shutdown entry");

    property p_tshd_opt;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        !i_opt_temp_shdn && mode != OMS_TEMP_SHDN |=> mode != OMS_TEMP_SHDN;
    endproperty
    a_tshd_opt: assert property (p_tshd_opt) else $error("temp shutdown without option");

    property p_therm_entry;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_temp_over && mode != OMS_TEMP_SHDN |=> mode == OMS_THERM_SHDN && o_overtemp_reset_flag;
    endproperty
    a_therm_entry: assert property (p_therm_entry) else $error("thermal entry missed");

    property p_therm_hold;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        mode == OMS_THERM_SHDN && !i_temp_returned |=> mode == OMS_THERM_SHDN;
    endproperty
    a_therm_hold: assert property (p_therm_hold) else $error("left thermal shutdown");

    property p_tx_block;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        mode == OMS_SLEEP || mode == OMS_THERM_SHDN |=> o_tx_to_bus;
    endproperty
    a_tx_block: assert property (p_tx_block) else $error("tx relayed while blocked");

    property p_sleep_wake;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        mode == OMS_SLEEP && !i_temp_over && remote_wake |=> mode == OMS_NORMAL;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake missed");

    property p_shdn_clear;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        mode == OMS_TEMP_SHDN && i_vcc_reset_n |=> !o_shdn_ctrl;
    endproperty
    a_shdn_clear: assert property (p_shdn_clear) else $error("shutdown bit kept");

    property p_rx_spike;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        $changed(o_rx) |-> $past(i_bus, 1) == o_rx && $past(i_bus, 2) == o_rx;
    endproperty
    a_rx_spike: assert property (p_rx_spike) else $error("rx followed a spike");

    property p_warn;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_temp_warning |=> o_warn_flag;
    endproperty
    a_warn: assert property (p_warn) else $error("warning flag not set");

    property p_slew_drop;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        mode == OMS_INIT |=> !o_low_slew;
    endproperty
    a_slew_drop: assert property (p_slew_drop) else $error("low slew survived init");

endmodule

`default_nettype wire

// file: sim/oms_host_model.sv
// host microcontroller model: drives the mode pin and tx line
// assumes its tasks are entered right after a rising edge of i_clk
`timescale 1ns/1ps
`default_nettype none

module oms_host_model
    import oms_pkg::*;
(
    input wire logic i_clk,
    output logic o_mode_pin,
    output logic o_tx
);
    initial begin
        o_mode_pin = 1'h1;
        o_tx = 1'h1;
    end

    // ==========================================================
    // requests
    // mode pin falls while tx stays high past the hold time
    task automatic ask_standby();
        o_tx <= 1'h1;
        o_mode_pin <= 1'h0;
        repeat (STANDBY_HOLD_CYCLES + 3) @(posedge i_clk);
    endtask

    task automatic local_wake();
        o_mode_pin <= 1'h1;
        @(posedge i_clk);
    endtask

    task automatic send_tx(input logic v);
        o_tx <= v;
        @(posedge i_clk);
    endtask
endmodule

`default_nettype wire

// file: sim/oms_sequencer_tb_top.sv
// self-checking bench for the operating mode sequencer
// assumes the host model in oms_host_model.sv; outputs sampled at rising edges
`timescale 1ns/1ps
`default_nettype none

module oms_sequencer_tb_top
    import oms_pkg::*;
;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic vrst_n = 1'h1, vgood = 1'h0, twarn = 1'h0, tover = 1'h0, tret = 1'h0;
    logic osleep = 1'h0, oshdn = 1'h0, bus = 1'h1;
    logic shwr = 1'h0, shd = 1'h0, lswr = 1'h0, lsd = 1'h0, wclr = 1'h0, oclr = 1'h0;
    logic mpin, tx, fpon_n, strobe, extr_n, txb, rx, lslew, shctl, wflag, otflag;
    logic [3:0] prereg;
    logic [3:0] fuse = 4'hA;
    logic [1:0] vsel, usel;
    oms_mode_e mode;
    oms_en_s en;
    int bad_count = 0;
    int check_count = 0;

    always #12.5 clk = ~clk;

    oms_host_model oms_host_model_i (.i_clk(clk), .o_mode_pin(mpin), .o_tx(tx));

    oms_sequencer #(.SHD_COUNT(50)) oms_sequencer_i (
        .i_ref_clk(clk), .i_rstn(rstn), .i_vcc_reset_n(vrst_n),
        .i_vcc_above_release(vgood), .i_temp_warning(twarn), .i_temp_over(tover),
        .i_temp_returned(tret), .i_opt_sleep(osleep), .i_opt_temp_shdn(oshdn),
        .i_mode_pin(mpin), .i_tx(tx), .i_bus(bus), .i_shdn_wr(shwr),
        .i_shdn_wdata(shd), .i_low_slew_wr(lswr), .i_low_slew_wdata(lsd),
        .i_warn_clear(wclr), .i_ot_clear(oclr), .i_fuse_data(fuse),
        .o_fuse_power_on_n(fpon_n), .o_latch_to_prereg_strobe(strobe),
        .o_prereg_settings(prereg), .o_vcc_sel(vsel), .o_uvr_sel(usel),
        .o_ext_reset_n(extr_n), .o_tx_to_bus(txb), .o_rx(rx), .o_low_slew(lslew),
        .o_shdn_ctrl(shctl), .o_warn_flag(wflag), .o_overtemp_reset_flag(otflag),
        .o_mode(mode), .o_enables(en));

    // ==========================================================
    // compare helpers
    task automatic chk_val(input string n, input logic [8:0] e, input logic [8:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_mode(input oms_mode_e e);
        chk_val("mode", 9'(e), 9'(mode));
    endtask

    // bounded wait, sampled before the edge's own updates land
    task automatic wait_mode(input oms_mode_e m, input int lim);
        for (int i = 0; i < lim && mode !== m; i++) @(posedge clk);
        chk_mode(m);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_init();
        int low;
        low = 0;
        chk_val("vcc_sel", 9'h0, 9'(vsel));
        vgood <= 1'h1;
        for (int i = 0; i < 30 && strobe !== 1'h1; i++) begin
            @(posedge clk);
            if (fpon_n === 1'h0) low++;
        end
        chk_val("fuse_low_cycles", 9'(FUSE_PULSE_CYCLES), 9'(low));
        chk_val("strobe", 9'h1, 9'(strobe));
        tick(2);
        chk_val("prereg", 9'hA, 9'(prereg));
        chk_val("uvr_sel", 9'h2, 9'(usel));
        chk_val("ext_reset_n", 9'h0, 9'(extr_n));
        wait_mode(OMS_NORMAL, RES_TIMEOUT_CYCLES + 10);
        chk_val("ext_reset_n", 9'h1, 9'(extr_n));
        chk_val("enables", 9'h1FF, 9'(en));
    endtask

    task automatic t_bus_io();
        oms_host_model_i.send_tx(1'h0);
        tick(1);
        chk_val("tx_to_bus", 9'h0, 9'(txb));
        oms_host_model_i.send_tx(1'h1);
        bus <= 1'h0;
        tick(2);
        bus <= 1'h1;
        tick(6);
        chk_val("rx_spike", 9'h1, 9'(rx));
        bus <= 1'h0;
        tick(DEBOUNCE_CYCLES + 3);
        chk_val("rx_low", 9'h0, 9'(rx));
        bus <= 1'h1;
        twarn <= 1'h1;
        tick(2);
        twarn <= 1'h0;
        tick(2);
        chk_val("warn_flag", 9'h1, 9'(wflag));
        // set and clear in one cycle: set must win
        twarn <= 1'h1;
        wclr <= 1'h1;
        tick(1);
        twarn <= 1'h0;
        wclr <= 1'h0;
        tick(1);
        chk_val("warn_set_wins", 9'h1, 9'(wflag));
        wclr <= 1'h1;
        tick(1);
        wclr <= 1'h0;
        tick(1);
        chk_val("warn_cleared", 9'h0, 9'(wflag));
    endtask

    task automatic t_standby();
        oms_host_model_i.ask_standby();
        wait_mode(OMS_STANDBY, 4);
        chk_val("trx_en", 9'h0, 9'(en.transceiver));
        chk_val("wake_en", 9'h1, 9'(en.wake_det));
        oms_host_model_i.local_wake();
        wait_mode(OMS_NORMAL, 4);
        oms_host_model_i.ask_standby();
        bus <= 1'h0;
        tick(WAKE_CYCLES - 100);
        chk_mode(OMS_STANDBY);
        wait_mode(OMS_NORMAL, 200);
        bus <= 1'h1;
        oms_host_model_i.local_wake();
    endtask

    task automatic t_temp_shdn();
        shwr <= 1'h1;
        shd <= 1'h1;
        tick(1);
        shwr <= 1'h0;
        tick(5);
        chk_mode(OMS_NORMAL);
        // vcc undervoltage wipes the shutdown bit and pulls the reset
        vrst_n <= 1'h0;
        tick(2);
        chk_val("ext_reset_n_vcc", 9'h0, 9'(extr_n));
        chk_val("shdn_ctrl_vcc", 9'h0, 9'(shctl));
        vrst_n <= 1'h1;
        oshdn <= 1'h1;
        shwr <= 1'h1;
        tick(1);
        shwr <= 1'h0;
        wait_mode(OMS_TEMP_SHDN, 4);
        chk_val("reg_en", 9'h0, 9'(en.regulator));
        chk_val("wake_en", 9'h0, 9'(en.wake_det));
        tick(40);
        chk_mode(OMS_TEMP_SHDN);
        wait_mode(OMS_NORMAL, 20);
        chk_val("shdn_ctrl", 9'h0, 9'(shctl));
        // standby may also enter temporary shutdown, mode pin low
        oms_host_model_i.ask_standby();
        chk_mode(OMS_STANDBY);
        shwr <= 1'h1;
        tick(1);
        shwr <= 1'h0;
        wait_mode(OMS_TEMP_SHDN, 4);
        wait_mode(OMS_NORMAL, 60);
        oms_host_model_i.local_wake();
        oshdn <= 1'h0;
    endtask

    task automatic t_thermal();
        lswr <= 1'h1;
        lsd <= 1'h1;
        tick(1);
        lswr <= 1'h0;
        tover <= 1'h1;
        wait_mode(OMS_THERM_SHDN, 4);
        chk_val("ot_flag", 9'h1, 9'(otflag));
        oms_host_model_i.send_tx(1'h0);
        tick(1);
        chk_val("tx_blocked", 9'h1, 9'(txb));
        oms_host_model_i.send_tx(1'h1);
        oms_host_model_i.ask_standby();
        oms_host_model_i.local_wake();
        bus <= 1'h0;
        tick(100);
        chk_mode(OMS_THERM_SHDN);
        tover <= 1'h0;
        tret <= 1'h1;
        fuse <= 4'h5;
        wait_mode(OMS_NORMAL, 150);
        chk_val("low_slew", 9'h0, 9'(lslew));
        chk_val("prereg_rerun", 9'h5, 9'(prereg));
        oclr <= 1'h1;
        tick(1);
        oclr <= 1'h0;
        tick(1);
        chk_val("ot_cleared", 9'h0, 9'(otflag));
        tret <= 1'h0;
        bus <= 1'h1;
    endtask

    task automatic t_sleep();
        osleep <= 1'h1;
        tick(1);
        oms_host_model_i.ask_standby();
        wait_mode(OMS_SLEEP, 4);
        chk_val("reg_en", 9'h0, 9'(en.regulator));
        oms_host_model_i.local_wake();
        tick(4);
        chk_mode(OMS_SLEEP);
        bus <= 1'h0;
        wait_mode(OMS_NORMAL, WAKE_CYCLES + 100);
        bus <= 1'h1;
    endtask

    // ==========================================================
    // verdict
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        tick(3);
        rstn <= 1'h1;
        tick(1);
        t_init();
        t_bus_io();
        t_standby();
        t_temp_shdn();
        t_thermal();
        t_sleep();
        tally_and_finish();
    end

    // sized for two long wake waits plus the short scenarios
    initial begin
        tick(30000);
        bad_count++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
